// ### common/spi_slave_pkg.sv
// Shared constants and carriers for the slave serial engine.
// Assumes a 32-bit AXI4-Lite register bus with a 5-bit byte address.
package spi_slave_pkg;

  localparam int REG_ADDR_W = 5;
  localparam int BYTE_BITS = 8;
  localparam int CNT_W = $clog2(BYTE_BITS);
  localparam int IRQ_BITS = 2;

  // Register byte addresses
  localparam logic [REG_ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [REG_ADDR_W-1:0] ADDR_DATA = 5'h04;
  localparam logic [REG_ADDR_W-1:0] ADDR_STAT = 5'h08;
  localparam logic [REG_ADDR_W-1:0] ADDR_ISTAT = 5'h0c;
  localparam logic [REG_ADDR_W-1:0] ADDR_ICLR = 5'h10;
  localparam logic [REG_ADDR_W-1:0] ADDR_IEN = 5'h14;

  // Interrupt bit positions
  localparam int IRQ_BYTE_POS = 0;
  localparam int IRQ_TXFREE_POS = 1;

  // Reset values
  localparam logic [5:0] CTRL_RESET = 6'h04;
  localparam logic [IRQ_BITS-1:0] IEN_RESET = 2'h0;
  localparam logic [2:0] PIN_RESET = 3'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register layout, bit 5 down to bit 0
  typedef struct packed {
    logic cpol;
    logic cpha;
    logic modeHi;
    logic modeLo;
    logic masterSel;
    logic enable;
  } ctrl_s;

  // Serial pins as seen after synchronisation
  typedef struct packed {
    logic sck;
    logic mosi;
    logic nss;
  } pins_s;

endpackage

// ### rtl/pin_sync.sv
// Two-stage synchroniser with edge detection for a group of pins.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/10ps
module pin_sync
  import spi_slave_pkg::*;
#(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_r <= INIT;
      sync_r <= INIT;
      prev_r <= INIT;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges come from the second and third stage only
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule

// ### rtl/spi_shifter.sv
// Receive and transmit shift registers with the bit counter.
// Assumes single-cycle edge strobes from synchronised serial clock.
`timescale 1ns/10ps
module spi_shifter
  import spi_slave_pkg::*;
#(
  parameter int BITS = BYTE_BITS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic sampleEdge,
  input wire logic shiftEdge,
  input wire logic mosiBit,
  input wire logic load,
  input wire logic [BITS-1:0] loadByte,
  output logic misoBit,
  output logic [BITS-1:0] rxByte,
  output logic byteDone,
  output logic [$clog2(BITS)-1:0] bitCount
);

  localparam logic [$clog2(BITS)-1:0] LAST = ($clog2(BITS))'(BITS - 1);

  logic [BITS-1:0] txSr_r;
  logic [BITS-1:0] rxSr_r;
  logic [BITS-1:0] rxByte_r;
  logic [$clog2(BITS)-1:0] cnt_r;
  logic done_r;

  wire [BITS-1:0] rxNext = {rxSr_r[BITS-2:0], mosiBit};
  wire lastBit = (cnt_r == LAST);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rxSr_r <= '0;
      rxByte_r <= '0;
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (clear) begin
        cnt_r <= '0;
      end else if (sampleEdge) begin
        rxSr_r <= rxNext;
        cnt_r <= lastBit ? '0 : cnt_r + 1'b1;
        if (lastBit) begin
          rxByte_r <= rxNext;
          done_r <= 1'b1;
        end
      end
    end
  end

  // Output shifts only between bits of a byte, never before the first one
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      txSr_r <= '0;
    end else if (load) begin
      txSr_r <= loadByte;
    end else if (shiftEdge && cnt_r != '0 && !clear) begin
      txSr_r <= {txSr_r[BITS-2:0], 1'b0};
    end
  end

  assign misoBit = txSr_r[BITS-1];
  assign rxByte = rxByte_r;
  assign byteDone = done_r;
  assign bitCount = cnt_r;

endmodule

// ### rtl/spi_slave_engine.sv
// Slave serial engine with AXI4-Lite registers and one interrupt line.
// Assumes an external master drives the serial clock and select pins.
// How it works
// - The engine works as a slave only while enabled and not set up as master.
// - Bits are taken from the data-in pin and offered on the data-out pin on the master's clock edges.
// - A counter of clock edges raises the byte done flag and stores the byte after eight bits.
// - Reading the data port returns the receive buffer.
// - The engine never begins a transfer itself; all activity follows the master's clock.
// - Writing the data port fills a transmit buffer separate from the shift register.
// - An empty shift register takes the transmit buffer at once.
// - A busy shift register takes the transmit buffer only after the last edge of a byte.
// - Four-wire slave mode is the reset default, with mode bits high 0 and low 1.
// - In four-wire mode the select pin enables the engine when low and idles it when high.
// - In four-wire mode each falling edge of select clears the bit counter.
// - With both mode bits 0 the engine runs three-wire and ignores the select pin.
// - In three-wire mode only leaving slave operation, by disabling the port or setting master select, clears the bit counter.
`timescale 1ns/10ps
module spi_slave_engine
  import spi_slave_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [REG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck,
  input wire logic mosi,
  input wire logic nss,
  output logic miso,
  output logic misoOe,
  output logic irq
);

  function automatic logic isMapped(input logic [REG_ADDR_W-1:0] a);
    isMapped = (a == ADDR_CTRL) || (a == ADDR_DATA) || (a == ADDR_STAT) ||
               (a == ADDR_ISTAT) || (a == ADDR_ICLR) || (a == ADDR_IEN);
  endfunction

  // Pin synchronisation
  pins_s pinLvl;
  pins_s pinRise;
  pins_s pinFall;

  pin_sync #(
    .W(3),
    .INIT(PIN_RESET)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .din({sck, mosi, nss}),
    .level(pinLvl),
    .rise(pinRise),
    .fall(pinFall)
  );

  // Register state
  ctrl_s ctrl_r;
  logic [IRQ_BITS-1:0] ien_r;
  logic [IRQ_BITS-1:0] istat_r;
  logic [7:0] txBuf_r;
  logic txFull_r;
  logic shiftFull_r;

  // Bus channel state
  logic awHeld_r;
  logic [REG_ADDR_W-1:0] awAddr_r;
  logic wHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Shifter results
  logic [7:0] rxByte;
  logic byteDone;
  logic misoBit;
  logic [CNT_W-1:0] bitCount;

  // Mode decode
  wire slaveMode = ctrl_r.enable && !ctrl_r.masterSel;
  wire fourWire = !ctrl_r.modeHi && ctrl_r.modeLo;
  wire threeWire = !ctrl_r.modeHi && !ctrl_r.modeLo;
  wire selected = threeWire || (fourWire && !pinLvl.nss);
  wire active = slaveMode && selected;

  // Edge selection from polarity and phase
  wire leadEdge = ctrl_r.cpol ? pinFall.sck : pinRise.sck;
  wire trailEdge = ctrl_r.cpol ? pinRise.sck : pinFall.sck;
  wire sampleEdge = active && (ctrl_r.cpha ? trailEdge : leadEdge);
  wire shiftEdge = active && (ctrl_r.cpha ? leadEdge : trailEdge);
  wire nssClear = fourWire && pinFall.nss;
  wire counterClear = !slaveMode || nssClear;

  // Write channel decode
  wire wrFire = awHeld_r && wHeld_r && !bvalid_r;
  wire wrOk = wrFire && isMapped(awAddr_r);
  wire wrLow = wrOk && wStrb_r[0];
  wire ctrlWrite = wrLow && (awAddr_r == ADDR_CTRL);
  wire dataWrite = wrLow && (awAddr_r == ADDR_DATA);
  wire ienWrite = wrLow && (awAddr_r == ADDR_IEN);
  wire iclrWrite = wrLow && (awAddr_r == ADDR_ICLR);
  wire [IRQ_BITS-1:0] clrMask = iclrWrite ? wData_r[IRQ_BITS-1:0] : '0;

  // Transmit buffer hand-over
  wire loadNow = txFull_r && (!shiftFull_r || byteDone);
  wire txFull_nxt = dataWrite ? 1'b1 : (loadNow ? 1'b0 : txFull_r);
  wire shiftFull_nxt = loadNow ? 1'b1 : (byteDone ? 1'b0 : shiftFull_r);

  // Interrupt events, set wins over clear
  logic [IRQ_BITS-1:0] events;
  assign events[IRQ_BYTE_POS] = byteDone;
  assign events[IRQ_TXFREE_POS] = loadNow;
  wire [IRQ_BITS-1:0] istat_nxt = (istat_r & ~clrMask) | events;

  spi_shifter #(
    .BITS(BYTE_BITS)
  ) u_shift (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(counterClear),
    .sampleEdge(sampleEdge),
    .shiftEdge(shiftEdge),
    .mosiBit(pinLvl.mosi),
    .load(loadNow),
    .loadByte(txBuf_r),
    .misoBit(misoBit),
    .rxByte(rxByte),
    .byteDone(byteDone),
    .bitCount(bitCount)
  );

  // Read decode
  wire arFire = s_axi_arvalid && !rvalid_r;
  wire [31:0] ctrlRd = {26'h0, ctrl_r};
  wire [31:0] dataRd = {24'h0, rxByte};
  wire [31:0] statRd = {24'h0, 1'b0, bitCount, 1'b0, active, shiftFull_r, txFull_r};
  wire [31:0] istatRd = {30'h0, istat_r};
  wire [31:0] ienRd = {30'h0, ien_r};
  wire [31:0] rdSel = (s_axi_araddr == ADDR_CTRL) ? ctrlRd :
                      (s_axi_araddr == ADDR_DATA) ? dataRd :
                      (s_axi_araddr == ADDR_STAT) ? statRd :
                      (s_axi_araddr == ADDR_ISTAT) ? istatRd :
                      (s_axi_araddr == ADDR_IEN) ? ienRd : 32'h0;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_r <= ctrl_s'(CTRL_RESET);
      ien_r <= IEN_RESET;
      istat_r <= '0;
      txBuf_r <= 8'h00;
      txFull_r <= 1'b0;
      shiftFull_r <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        ctrl_r <= ctrl_s'(wData_r[5:0]);
      end
      if (ienWrite) begin
        ien_r <= wData_r[IRQ_BITS-1:0];
      end
      if (dataWrite) begin
        txBuf_r <= wData_r[7:0];
      end
      istat_r <= istat_nxt;
      txFull_r <= txFull_nxt;
      shiftFull_r <= shiftFull_nxt;
    end
  end

  // Write address and data are taken in either order
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
      wHeld_r <= 1'b0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wrFire) begin
      bvalid_r <= 1'b1;
      bresp_r <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (arFire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rdSel;
      rresp_r <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready = !wHeld_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Data out is driven only while selected as an active slave
  assign miso = misoBit;
  assign misoOe = active;
  assign irq = |(istat_r & ien_r);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_slave_gate: assert property (!slaveMode |=> bitCount == '0)
    else $error("counter not held clear outside slave operation");

  a_byte_capture: assert property (
    sampleEdge && bitCount == 3'h7 |=> byteDone && rxByte[0] == $past(pinLvl.mosi))
    else $error("last bit not captured into receive buffer");

  a_done_flag: assert property (byteDone |=> istat_r[IRQ_BYTE_POS])
    else $error("byte done flag not set");

  a_rx_read: assert property (
    arFire && s_axi_araddr == ADDR_DATA |=> rvalid_r && rdata_r[7:0] == $past(rxByte))
    else $error("data port read does not return receive buffer");

  a_no_self_start: assert property (
    !sampleEdge && !counterClear |=> bitCount == $past(bitCount) && !byteDone)
    else $error("bit counter moved without a master clock edge");

  a_tx_buffer: assert property (
    dataWrite |=> txFull_r && txBuf_r == $past(wData_r[7:0]))
    else $error("data port write not placed in transmit buffer");

  a_empty_load: assert property (
    txFull_r && !shiftFull_r |=> shiftFull_r && misoBit == $past(txBuf_r[7]))
    else $error("empty shift register not loaded at once");

  a_busy_hold: assert property (
    txFull_r && shiftFull_r && !byteDone && !dataWrite |=> txFull_r && shiftFull_r)
    else $error("transmit buffer moved before end of byte");

  a_reset_mode: assert property ($past(reset) |-> fourWire && !ctrl_r.enable)
    else $error("reset mode is not four-wire");

  a_nss_idle: assert property (
    fourWire && pinLvl.nss |-> !active && !sampleEdge && !misoOe)
    else $error("engine active while select is high");

  a_nss_clear: assert property (slaveMode && nssClear |=> bitCount == '0)
    else $error("select falling edge did not clear counter");

  a_three_wire: assert property (
    threeWire && slaveMode && pinFall.nss && !sampleEdge |=> bitCount == $past(bitCount))
    else $error("select pin moved the counter in three-wire mode");

  a_single_edge: assert property (pinRise.sck |=> !pinRise.sck ##1 !pinRise.sck)
    else $error("clock edge strobe longer than one cycle");

  c_four_wire_byte: cover property (fourWire && byteDone);
  c_three_wire_byte: cover property (threeWire && byteDone);
  c_end_load: cover property (loadNow && byteDone);
  c_mid_clear: cover property (nssClear && slaveMode && bitCount != '0);
  c_phase_one: cover property (ctrl_r.cpha && byteDone);

endmodule

// ### test/spi_master_model.sv
// Behavioural serial master facing the slave engine, any clock mode, MSB first.
// Assumes the bench calls xfer from its main sequence only.
`timescale 1ns/10ps
module spi_master_model (
  output logic sck,
  output logic mosi,
  output logic nss,
  input wire logic miso
);
  localparam realtime HALF = 62.5;
  bit pol = 1'b0;
  bit pha = 1'b0;

  // Clock stands still at its idle level pol, low from start, and select is high between frames
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    nss = 1'b1;
  end

  // Moves the idle clock level while deselected
  task automatic set_mode(input bit cpol, input bit cpha);
    pol = cpol;
    pha = cpha;
    sck = cpol;
    #(HALF);
  endtask

  // Sole slave on this bus in either mode
  // Clocks the top n bits of tx; sel lowers select around them
  task automatic xfer(input logic [7:0] tx, input int n, input bit sel, output logic [7:0] rx);
    rx = 8'h00;
    if (sel) begin
      nss = 1'b0;
    end
    // Select leads the first edge by far more than two system clocks
    #(HALF);
    for (int i = 7; i > 7 - n; i--) begin
      if (!pha) begin
        mosi = tx[i];
      end
      #(HALF);
      sck = ~pol;
      // Leading edge samples in phase 0 and launches data in phase 1
      if (pha) begin
        mosi = tx[i];
      end else begin
        rx = {rx[6:0], miso};
      end
      #(HALF);
      sck = pol;
      if (pha) begin
        rx = {rx[6:0], miso};
      end
    end
    #(HALF);
    mosi = ~mosi;
    nss = 1'b1;
    // Select stays high long enough for the engine to see the next falling edge
    #(HALF);
  endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the slave serial engine.
// Assumes the engine package and the serial master model are compiled first.
`timescale 1ns/10ps
module testbench;
  import spi_slave_pkg::*;
  logic sys_clk, reset, awV, awR, wV, wR, bV, bR, arV, arR, rV, rR;
  logic sck, mosi, nss, miso, misoOe, irq, misoLine;
  logic [REG_ADDR_W-1:0] awA, arA;
  logic [31:0] wD, rD, rdv;
  logic [1:0] bResp, rResp, lastResp;
  logic [7:0] rx;
  int n_errors = 0;
  int n_tests = 0;

  // Undriven data-out line shows the inverse of its last value
  assign misoLine = misoOe ? miso : ~miso;

  spi_slave_engine spi_slave_engine_inst (.sys_clk(sys_clk), .reset(reset),
    .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp),
    .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
    .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV),
    .s_axi_rready(rR), .sck(sck), .mosi(mosi), .nss(nss), .miso(miso), .misoOe(misoOe),
    .irq(irq));
  spi_master_model spi_master_model_inst (.sck(sck), .mosi(mosi), .nss(nss), .miso(misoLine));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chkIrq(input logic exp);
    @(negedge sys_clk);
    chk("irq", irq, exp);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bit aT, wT, got;
    got = 0;
    @(posedge sys_clk);
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    bR <= 1'b1;
    while (!got) begin
      @(negedge sys_clk);
      aT = awV && awR;
      wT = wV && wR;
      got = bV;
      lastResp = bResp;
      @(posedge sys_clk);
      if (aT) awV <= 1'b0;
      if (wT) wV <= 1'b0;
    end
    bR <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    bit aT, got;
    got = 0;
    @(posedge sys_clk);
    arA <= a;
    arV <= 1'b1;
    rR <= 1'b1;
    while (!got) begin
      @(negedge sys_clk);
      aT = arV && arR;
      got = rV;
      rdv = rD;
      lastResp = rResp;
      @(posedge sys_clk);
      if (aT) arV <= 1'b0;
    end
    rR <= 1'b0;
  endtask

  task automatic t_defaults();
    rd(ADDR_CTRL);
    chk("ctrl", rdv, 32'h04);
    chk("misoOe", misoOe, 1'b0);
    rd(5'h18);
    chk("rresp", lastResp, RESP_SLVERR);
    wr(5'h1c, 32'h01);
    chk("bresp", lastResp, RESP_SLVERR);
    rd(ADDR_IEN);
    chk("ien", rdv, 32'h00);
  endtask

  task automatic t_four_wire();
    wr(ADDR_IEN, 32'h01);
    wr(ADDR_CTRL, 32'h05);
    wr(ADDR_DATA, 32'ha5);
    rd(ADDR_STAT);
    chk("shift loaded", rdv[1:0], 2'b10);
    chk("misoOe idle", misoOe, 1'b0);
    spi_master_model_inst.xfer(8'h3c, 8, 1'b1, rx);
    chk("out byte", rx, 8'ha5);
    chkIrq(1'b1);
    rd(ADDR_DATA);
    chk("in byte", rdv, 32'h3c);
    rd(ADDR_ISTAT);
    chk("done flag", rdv[0], 1'b1);
    wr(ADDR_IEN, 32'h00);
    chkIrq(1'b0);
    wr(ADDR_ICLR, 32'h03);
    wr(ADDR_IEN, 32'h01);
    chkIrq(1'b0);
  endtask

  task automatic t_double();
    wr(ADDR_DATA, 32'h11);
    wr(ADDR_DATA, 32'h22);
    rd(ADDR_STAT);
    chk("both full", rdv[1:0], 2'b11);
    spi_master_model_inst.xfer(8'h5a, 8, 1'b1, rx);
    chk("first out", rx, 8'h11);
    spi_master_model_inst.xfer(8'h96, 8, 1'b1, rx);
    chk("second out", rx, 8'h22);
    rd(ADDR_DATA);
    chk("last in", rdv, 32'h96);
  endtask

  task automatic t_select();
    wr(ADDR_ICLR, 32'h03);
    wr(ADDR_DATA, 32'hc3);
    spi_master_model_inst.xfer(8'hff, 8, 1'b0, rx);
    rd(ADDR_ISTAT);
    chk("deselected", rdv[0], 1'b0);
    spi_master_model_inst.xfer(8'hf0, 3, 1'b1, rx);
    spi_master_model_inst.xfer(8'h69, 8, 1'b1, rx);
    rd(ADDR_DATA);
    chk("after restart", rdv, 32'h69);
  endtask

  task automatic t_three_wire();
    wr(ADDR_CTRL, 32'h01);
    chk("misoOe 3w", misoOe, 1'b1);
    spi_master_model_inst.xfer(8'ha0, 3, 1'b0, rx);
    spi_master_model_inst.xfer(8'he7, 8, 1'b1, rx);
    rd(ADDR_DATA);
    chk("3w no select clear", rdv, 32'hbc);
    wr(ADDR_CTRL, 32'h00);
    wr(ADDR_CTRL, 32'h01);
    spi_master_model_inst.xfer(8'he7, 8, 1'b0, rx);
    rd(ADDR_DATA);
    chk("3w byte", rdv, 32'he7);
  endtask

  task automatic t_inactive();
    logic [5:0] modes [2] = '{6'h03, 6'h09};
    wr(ADDR_ICLR, 32'h03);
    foreach (modes[i]) begin
      wr(ADDR_CTRL, {26'h0, modes[i]});
      spi_master_model_inst.xfer(8'h55, 8, 1'b1, rx);
      chk("misoOe off", misoOe, 1'b0);
      rd(ADDR_ISTAT);
      chk("no byte", rdv[0], 1'b0);
    end
  endtask

  task automatic t_modes();
    for (int m = 1; m < 4; m++) begin
      spi_master_model_inst.set_mode(m[1], m[0]);
      wr(ADDR_CTRL, {26'h0, m[1], m[0], 4'h5});
      wr(ADDR_DATA, 32'h9d);
      spi_master_model_inst.xfer(8'h4b, 8, 1'b1, rx);
      chk("mode out", rx, 8'h9d);
      rd(ADDR_DATA);
      chk("mode in", rdv, 32'h4b);
    end
    spi_master_model_inst.set_mode(1'b0, 1'b0);
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    awA = '0;
    arA = '0;
    wD = '0;
    awV = 1'b0;
    wV = 1'b0;
    bR = 1'b0;
    arV = 1'b0;
    rR = 1'b0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    t_defaults();
    t_four_wire();
    t_double();
    t_select();
    t_three_wire();
    t_inactive();
    t_modes();
    tally_and_finish();
  end
endmodule
